// File: hw/mbw_pkg.sv
package mbw_pkg;

  // ==========================================================
  // function codes and coil constants
  localparam logic [7:0]  FC_WR_COIL  = 8'h05;
  localparam logic [7:0]  FC_WR_REG   = 8'h06;
  localparam logic [7:0]  FC_WR_COILS = 8'h0f;
  localparam logic [7:0]  FC_WR_REGS  = 8'h10;
  localparam logic [15:0] COIL_ON     = 16'hff00;
  localparam logic [15:0] COIL_OFF    = 16'h0000;

  // ==========================================================
  // frame layout: byte positions within a frame, reply size and reply length value
  localparam int unsigned POS_LEN_LO  = 5;
  localparam int unsigned POS_FC      = 7;
  localparam int unsigned POS_ADDR_HI = 8;
  localparam int unsigned POS_ADDR_LO = 9;
  localparam int unsigned POS_VAL_HI  = 10;
  localparam int unsigned POS_VAL_LO  = 11;
  localparam int unsigned POS_BCNT    = 12;
  localparam int unsigned POS_DATA    = 13;
  localparam int unsigned RSP_BYTES   = 12;
  localparam logic [7:0]  RSP_LEN     = 8'h06;

  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_WORD    = 16'h0000;

  typedef enum logic [2:0] {
    ST_HDR  = 3'b000,
    ST_DATA = 3'b001,
    ST_APPLY = 3'b010,
    ST_RESP = 3'b011,
    ST_DROP = 3'b100
  } state_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } byte_beat_type;

endpackage

// File: hw/mbw_coil_bit.sv
`timescale 1ns/1ps
`default_nettype none
// one output bit: applies a single-coil or multi-coil request
module mbw_coil_bit
  import mbw_pkg::*;
#(
  parameter int unsigned IDX = 0
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        wr_en_in,
  input  wire logic [15:0] start_in,
  input  wire logic [15:0] qty_in,
  input  wire logic [15:0] value_in,
  input  wire logic        multi_in,
  input  wire logic [63:0] bits_in,
  output logic             state_out
);
  logic        state_ff;
  logic        nxt_state;
  logic [15:0] rel;

  always_comb begin
    rel       = 16'(IDX) - start_in;
    nxt_state = state_ff;
    if (wr_en_in) begin
      if (multi_in) begin
        // (RULE_09) lsb first
        if (16'(IDX) >= start_in && rel < qty_in) begin
          nxt_state = bits_in[rel[5:0]];
        end
      end else if (16'(IDX) == start_in) begin
        // (RULE_02) on constant
        if (value_in == COIL_ON) begin
          nxt_state = 1'b1;
        // (RULE_03) off constant
        end else if (value_in == COIL_OFF) begin
          nxt_state = 1'b0;
        end
        // (RULE_04) other values ignored
      end
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign state_out = state_ff;
endmodule
`default_nettype wire

// File: hw/mbw_handler.sv
// Functional notes
// (RULE_01) code 0x05 changes exactly the one output named by the address.
// (RULE_02) a single-coil value of ff00 turns the output on.
// (RULE_03) a single-coil value of 0000 turns the output off.
// (RULE_04) any other single-coil value leaves the output unchanged.
// (RULE_05) single-coil reply echoes the request after the output is set.
// (RULE_06) code 0x06 writes one analog register, numbered from zero.
// (RULE_07) single-register reply echoes the request after the write.
// (RULE_08) code 0x0f forces a contiguous run of coils from a zero-based start.
// (RULE_09) coil data is one bit per coil, first coil in bit 0 of byte 0.
// (RULE_10) multi-coil reply holds code, start and quantity only.
// (RULE_11) code 0x10 writes a block of registers, two bytes each.
// (RULE_12) multi-register reply holds code, start and quantity only.
// (RULE_13) every 16-bit value travels high byte first.
// (RULE_14) multi-coil byte count is quantity/8 rounded up; pad bits ignored.
// (RULE_15) reply copies transaction and unit ids; length counts what follows.
// (RULE_16) a write outside the implemented range changes nothing.
`timescale 1ns/1ps
`default_nettype none
module mbw_handler
  import mbw_pkg::*;
#(
  parameter int unsigned NUM_DO = 3,
  parameter int unsigned NUM_AO = 2
) (
  input  wire logic              clk_in,
  input  wire logic              resetn_in,
  input  wire byte_beat_type     rx_in,
  input  wire logic              rx_valid_in,
  output logic                   rx_ready_out,
  output byte_beat_type          tx_out,
  output logic                   tx_valid_out,
  input  wire logic              tx_ready_in,
  output logic [NUM_DO-1:0]      do_out,
  output logic [NUM_AO*16-1:0]   ao_out,
  output logic                   reject_out
);

  // elaboration check: coil data and register index are 6 bits wide
  if (NUM_DO < 1 || NUM_DO > 64 || NUM_AO < 1 || NUM_AO > 64) begin : g_cfg
    $error("unsupported output counts");
  end

  // ==========================================================
  // state
  typedef struct packed {
    state_type       st;
    logic [7:0]      cnt;
    logic [0:11][7:0] hdr;
    logic [7:0]      byte_hold;
    logic [63:0]     bits;
    logic [15:0]     wrptr;
    logic            bad;
    logic            apply;
    logic [7:0]      txd;
    logic            txlast;
    logic            txv;
    logic            rej;
    logic [NUM_AO*16-1:0] ao;
  } state_s_type;

  state_s_type s_ff;
  state_s_type nxt;

  logic [7:0]           fc;
  logic [15:0]          start;
  logic [15:0]          qty;
  logic [15:0]          value;
  logic [16:0]          end_addr;
  logic                 range_ok;
  logic                 fc_ok;
  logic [7:0]           exp_bcnt;

  // (RULE_13) high byte first
  assign fc    = s_ff.hdr[POS_FC];
  assign start = {s_ff.hdr[POS_ADDR_HI], s_ff.hdr[POS_ADDR_LO]};
  assign value = {s_ff.hdr[POS_VAL_HI], s_ff.hdr[POS_VAL_LO]};
  assign qty   = (fc == FC_WR_COILS || fc == FC_WR_REGS) ? value : 16'h0001;
  assign end_addr = 17'(start) + 17'(qty);
  assign fc_ok = fc == FC_WR_COIL || fc == FC_WR_REG ||
                 fc == FC_WR_COILS || fc == FC_WR_REGS;
  // (RULE_14) ceil(qty/8)
  assign exp_bcnt = (fc == FC_WR_COILS) ? 8'((qty + 16'h0007) >> 3)
                                        : 8'(qty << 1);

  // (RULE_16) range check
  always_comb begin
    if (fc == FC_WR_COIL || fc == FC_WR_COILS) begin
      range_ok = qty != 16'h0000 && end_addr <= 17'(NUM_DO);
    end else begin
      range_ok = qty != 16'h0000 && end_addr <= 17'(NUM_AO);
    end
  end

  // ==========================================================
  // request parser and reply sender
  always_comb begin
    nxt       = s_ff;
    nxt.apply = 1'b0;
    nxt.rej   = 1'b0;
    rx_ready_out = s_ff.st == ST_HDR || s_ff.st == ST_DATA ||
                   s_ff.st == ST_DROP;
    unique case (s_ff.st)
      ST_HDR: begin
        if (rx_valid_in) begin
          nxt.hdr[s_ff.cnt[3:0]] = rx_in.data;
          nxt.cnt = s_ff.cnt + 8'h01;
          if (rx_in.last) begin
            nxt.cnt = RST_BYTE;
            if (s_ff.cnt == 8'(RSP_BYTES - 1) && fc_ok && range_ok &&
                (fc == FC_WR_COIL || fc == FC_WR_REG)) begin
              nxt.st = ST_APPLY;
            end else begin
              nxt.rej = 1'b1;
            end
          end else if (s_ff.cnt == 8'(RSP_BYTES - 1)) begin
            nxt.bits  = '0;
            nxt.wrptr = start;
            // quantity low byte is still arriving: range waits for count
            nxt.bad   = !(fc == FC_WR_COILS || fc == FC_WR_REGS);
            nxt.st    = ST_DATA;
          end else if (s_ff.cnt == 8'(RSP_BYTES)) begin
            nxt.st = ST_DROP;
          end
        end
      end
      ST_DATA: begin
        if (rx_valid_in) begin
          nxt.cnt = s_ff.cnt + 8'h01;
          if (s_ff.cnt == 8'(POS_BCNT)) begin
            if (rx_in.data != exp_bcnt || !range_ok) begin
              nxt.bad = 1'b1;
            end
          end else if (fc == FC_WR_COILS) begin
            // (RULE_09) byte k holds coils 8k..8k+7
            if (s_ff.cnt < 8'(POS_DATA + 8)) begin
              nxt.bits[(s_ff.cnt - 8'(POS_DATA)) * 8 +: 8] = rx_in.data;
            end
          end else if (s_ff.cnt[0] == 1'b1) begin
            nxt.byte_hold = rx_in.data;
          end else if (!s_ff.bad) begin
            // (RULE_11) written word by word; a frame refused at its end drops only its last word
            nxt.ao[s_ff.wrptr[5:0] * 16 +: 16] = {s_ff.byte_hold, rx_in.data};
            nxt.wrptr = s_ff.wrptr + 16'h0001;
          end
          if (rx_in.last) begin
            nxt.cnt = RST_BYTE;
            if (nxt.bad || s_ff.cnt != 8'(POS_BCNT) + exp_bcnt) begin
              nxt.rej = 1'b1;
              nxt.st  = ST_HDR;
              // (RULE_16) last word of a refused frame dropped
              nxt.ao  = s_ff.ao;
            end else begin
              nxt.st = ST_APPLY;
            end
          end
        end
      end
      ST_APPLY: begin
        nxt.apply = 1'b1;
        if (fc == FC_WR_REG) begin
          // (RULE_06) zero-based register index
          nxt.ao[start[5:0] * 16 +: 16] = value;
        end
        nxt.st = ST_RESP;
      end
      ST_RESP: begin
        // (RULE_05) (RULE_07) reply starts after apply cycle
        if (!s_ff.txv || tx_ready_in) begin
          nxt.txv    = 1'b1;
          // (RULE_15) ids copied, length fixed at six
          // (RULE_10) (RULE_12) code, start, quantity only
          nxt.txd    = (s_ff.cnt == 8'(POS_LEN_LO)) ? RSP_LEN
                                                   : s_ff.hdr[s_ff.cnt[3:0]];
          nxt.txlast = s_ff.cnt == 8'(RSP_BYTES - 1);
          nxt.cnt    = s_ff.cnt + 8'h01;
          if (s_ff.txv && s_ff.txlast) begin
            nxt.txv = 1'b0;
            nxt.cnt = RST_BYTE;
            nxt.st  = ST_HDR;
          end
        end
      end
      ST_DROP: begin
        if (rx_valid_in && rx_in.last) begin
          nxt.rej = 1'b1;
          nxt.st  = ST_HDR;
          nxt.cnt = RST_BYTE;
        end
      end
      default: begin
        nxt.st = ST_HDR;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt;
    end
  end

  // ==========================================================
  // digital outputs
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DO; gi++) begin : g_do
      // (RULE_01) (RULE_08) per-output apply
      mbw_coil_bit #(
        .IDX (gi)
      ) u_bit (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .wr_en_in  (s_ff.apply && (fc == FC_WR_COIL || fc == FC_WR_COILS)),
        .start_in  (start),
        .qty_in    (qty),
        .value_in  (value),
        .multi_in  (fc == FC_WR_COILS),
        .bits_in   (s_ff.bits),
        .state_out (do_out[gi])
      );
    end
  endgenerate

  assign ao_out       = s_ff.ao;
  assign tx_out       = '{data: s_ff.txd, last: s_ff.txlast};
  assign tx_valid_out = s_ff.txv;
  assign reject_out   = s_ff.rej;

endmodule
`default_nettype wire

// File: test/mbw_handler_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mbw_handler_assertions
  import mbw_pkg::*;
#(
  parameter int unsigned NUM_DO = 3,
  parameter int unsigned NUM_AO = 2
) (
  input  wire logic                 clk_in,
  input  wire logic                 resetn_in,
  input  wire byte_beat_type        rx_in,
  input  wire logic                 rx_valid_in,
  input  wire logic                 rx_ready_out,
  input  wire byte_beat_type        tx_out,
  input  wire logic                 tx_valid_out,
  input  wire logic                 tx_ready_in,
  input  wire logic [NUM_DO-1:0]    do_out,
  input  wire logic [NUM_AO*16-1:0] ao_out,
  input  wire logic                 reject_out
);
  // ==========================================================
  // reply beat counter
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [3:0] beat_ff;
  wire logic tx_take = tx_valid_out && tx_ready_in;
  wire logic rx_end = rx_valid_in && rx_ready_out && rx_in.last;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      beat_ff <= 4'h0;
    else if (tx_take)
      beat_ff <= tx_out.last ? 4'h0 : beat_ff + 4'h1;
  end
  a_reply_timing : assert property (
    rx_end |=> (reject_out or ##2 tx_valid_out)) else $error("late reply");
  a_do_with_reply : assert property (
    $changed(do_out) |-> $rose(tx_valid_out)) else $error("early coil");
  a_tx_hold : assert property (
    tx_valid_out && !tx_ready_in |=> tx_valid_out && $stable(tx_out))
    else $error("reply byte dropped");
  a_reply_quiet : assert property (
    tx_valid_out |-> !rx_ready_out ##1 ($stable(do_out) && $stable(ao_out)))
    else $error("change during reply");
  a_reply_count : assert property (
    tx_take |-> tx_out.last == (beat_ff == 4'hb)) else $error("reply size");
  a_len_field : assert property (
    tx_take && beat_ff == 4'h5 |-> tx_out.data == RSP_LEN)
    else $error("length field");
  a_reject_clean : assert property (
    reject_out |-> $stable(do_out) ##1 ($stable(do_out) && !tx_valid_out))
    else $error("reject changed state");
  a_reject_pulse : assert property (
    reject_out |=> !reject_out) else $error("long reject");
endmodule
bind mbw_handler mbw_handler_assertions #(
  .NUM_DO(NUM_DO),
  .NUM_AO(NUM_AO)
) u_chk (
  .clk_in       (clk_in),
  .resetn_in    (resetn_in),
  .rx_in        (rx_in),
  .rx_valid_in  (rx_valid_in),
  .rx_ready_out (rx_ready_out),
  .tx_out       (tx_out),
  .tx_valid_out (tx_valid_out),
  .tx_ready_in  (tx_ready_in),
  .do_out       (do_out),
  .ao_out       (ao_out),
  .reject_out   (reject_out)
);
`default_nettype wire

// File: test/mbw_client.sv
`timescale 1ns/1ps
`default_nettype none
module mbw_client
  import mbw_pkg::*;
(
  input  wire logic          clk_in,
  input  wire logic          slow_in,
  output byte_beat_type      rx_out,
  output logic               rx_valid_out,
  input  wire logic          rx_ready_in,
  input  wire byte_beat_type tx_in,
  input  wire logic          tx_valid_in,
  output logic               tx_ready_out
);
  // ==========================================================
  // request driver and reply sink
  logic [7:0] rsp[$];
  initial begin
    rx_out = '0;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // a slow client holds tx_ready_out low on every other cycle
  always @(posedge clk_in) begin
    if (tx_valid_in && tx_ready_out) rsp.push_back(tx_in.data);
    tx_ready_out <= slow_in ? !tx_ready_out : 1'b1;
  end
  task automatic send(input logic [7:0] f[$]);
    @(posedge clk_in);
    for (int i = 0; i < f.size(); i++) begin
      rx_out <= '{data: f[i], last: (i == f.size() - 1)};
      rx_valid_out <= 1'b1;
      @(negedge clk_in);
      while (!rx_ready_in) @(negedge clk_in);
      @(posedge clk_in);
    end
    // released line shows inverted data, never the stale byte
    rx_out <= '{data: ~f[f.size()-1], last: 1'b0};
    rx_valid_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

// File: test/mbw_handler_tb.sv
`timescale 1ns/1ps
`default_nettype none
module mbw_handler_tb
  import mbw_pkg::*;
;
  // ==========================================================
  // harness
  typedef logic [7:0] bq_type[$];
  logic          clk_in, resetn_in, slow;
  byte_beat_type rx, tx;
  logic          rx_valid, rx_ready, tx_valid, tx_ready, reject;
  logic [2:0]    do_w;
  logic [31:0]   ao_w;
  bq_type        nil;
  int            n_fail = 0;
  int            check_count = 0;
  mbw_handler u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .rx_in(rx),
    .rx_valid_in(rx_valid), .rx_ready_out(rx_ready), .tx_out(tx),
    .tx_valid_out(tx_valid), .tx_ready_in(tx_ready), .do_out(do_w),
    .ao_out(ao_w), .reject_out(reject));
  mbw_client u_cli (.clk_in(clk_in), .slow_in(slow), .rx_out(rx),
    .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .tx_in(tx),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  task automatic finish_test;
    if (n_fail == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic bq_type mk(input logic [7:0] fc, input logic [15:0] a,
                                input logic [15:0] v, input bq_type x);
    bq_type f;
    f = '{8'h12, 8'h34, 8'h00, 8'h00, 8'h00, 8'h06 + 8'(x.size()), 8'h07,
          fc, a[15:8], a[7:0], v[15:8], v[7:0]};
    return {f, x};
  endfunction
  // ok: 0 refused, 1 replied, 2 either
  task automatic run(input bq_type f, input int ok);
    logic rej;
    rej = 1'b0;
    u_cli.rsp.delete();
    u_cli.send(f);
    for (int i = 0; i < 80 && u_cli.rsp.size() < 12; i++) begin
      @(negedge clk_in);
      rej = rej | reject;
    end
    if (ok != 2) chk("refused", 32'(ok == 0), 32'(rej));
    if (ok != 2)
      chk("reply size", ok == 1 ? 12 : 0, u_cli.rsp.size());
    for (int i = 0; i < 12 && ok == 1; i++)
      chk("reply byte", i == 5 ? 8'h06 : f[i], u_cli.rsp[i]);
  endtask
  task automatic t_single;
    run(mk(FC_WR_COIL, 16'h0001, COIL_ON, nil), 1);
    chk("coil on", 3'h2, do_w);
    run(mk(FC_WR_COIL, 16'h0002, COIL_ON, nil), 1);
    chk("one coil", 3'h6, do_w);
    run(mk(FC_WR_COIL, 16'h0001, COIL_OFF, nil), 1);
    chk("coil off", 3'h4, do_w);
    run(mk(FC_WR_COIL, 16'h0002, 16'h00ff, nil), 2);
    chk("bad value", 3'h4, do_w);
    run(mk(FC_WR_COIL, 16'h0003, COIL_ON, nil), 0);
    chk("coil range", 3'h4, do_w);
  endtask
  task automatic t_coils;
    run(mk(FC_WR_COILS, 16'h0000, 16'h0002, '{8'h01, 8'h02}), 1);
    chk("coil run", 3'h6, do_w);
    run(mk(FC_WR_COILS, 16'h0001, 16'h0002, '{8'h01, 8'hfd}), 1);
    chk("pad bits", 3'h2, do_w);
    run(mk(FC_WR_COILS, 16'h0000, 16'h0003,
           '{8'h02, 8'h07, 8'h00}), 0);
    chk("byte count", 3'h2, do_w);
  endtask
  task automatic t_regs;
    run(mk(FC_WR_REG, 16'h0001, 16'h55ff, nil), 1);
    chk("reg write", 32'h55ff_0000, ao_w);
    run(mk(FC_WR_REGS, 16'h0000, 16'h0002,
           '{8'h04, 8'h00, 8'h0a, 8'h01, 8'h02}), 1);
    chk("reg block", 32'h0102_000a, ao_w);
    run(mk(FC_WR_REG, 16'h0002, 16'h1234, nil), 0);
    chk("reg range", 32'h0102_000a, ao_w);
    run(mk(8'h03, 16'h0000, 16'h0001, nil), 0);
    chk("bad code", 32'h0102_000a, ao_w);
    run(mk(FC_WR_REGS, 16'h0000, 16'h0000, '{8'h00}), 0);
    chk("zero qty", 32'h0102_000a, ao_w);
  endtask
  initial begin
    resetn_in = 1'b0;
    slow = 1'b0;
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_single();
    slow <= 1'b1;
    t_coils();
    t_regs();
    finish_test();
  end
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
endmodule
`default_nettype wire
